// file: src/psk_clock_buffer.sv
// psk_clock_buffer: logic model of a programmable skew clock buffer with an apb slave.
// assumes reference and feedback pins are synchronous to the core clock, which
// serves as the tap clock: one skew_time_unit is one core clock period.
//
// Overview of operation
// - all selects open gives eight aligned outputs
// - loop aligns feedback rising edge to reference
// - pairs skew up to six units around reference
// - skew seen equals own minus feedback skew
// - pair four high-high gives inverted outputs
// - inverted feedback inverts the other pairs
// - divide-by-four feedback gives four-times outputs
// - divide-by-two pair runs at half rate
// - half and quarter outputs fall together
// - range tied low gives the lowest range
// - dividers add no delay of their own
// - all pair functions work at once
// - nine functions decoded from two selects
// - taps per period are 44, 26, 16
`timescale 1ns/1ns
module psk_clock_buffer (
    // clock and reset
    input  wire logic                          I_CORE_CLK,
    input  wire logic                          I_RST,
    // apb slave
    input  wire logic                          I_PSEL,
    input  wire logic                          I_PENABLE,
    input  wire logic                          I_PWRITE,
    input  wire logic [psk_pkg::ADDR_W-1:0]    I_PADDR,
    input  wire logic [psk_pkg::DATA_W-1:0]    I_PWDATA,
    output logic [psk_pkg::DATA_W-1:0]         O_PRDATA,
    output logic                               O_PREADY,
    output logic                               O_PSLVERR,
    // clock pins
    input  wire logic                          I_REF_CLOCK,
    input  wire logic                          I_FEEDBACK_INPUT,
    output wire logic [1:0]                    O_OUTPUT_PAIR_ONE,
    output wire logic [1:0]                    O_OUTPUT_PAIR_TWO,
    output wire logic [1:0]                    O_OUTPUT_PAIR_THREE,
    output wire logic [1:0]                    O_OUTPUT_PAIR_FOUR
);
    import psk_pkg::*;

    logic [1:0]             range_select;
    logic [15:0]            pair_sel;
    logic [DATA_W-1:0]      rdata;
    logic                   apb_setup;
    logic                   apb_access;
    logic [7:0]             taps;
    logic [7:0]             phase;
    logic                   ref_prev;
    logic                   feedback_prev;
    logic                   ref_rise;
    logic                   feedback_rise;
    logic                   slip;
    logic                   aligned;
    logic [2:0]             hit_cnt;
    psk_loop_state_t        loop_state;
    psk_kind_t              kind [PAIR_CNT];
    logic signed [4:0]      skew [PAIR_CNT];
    logic [1:0]             pair_q [PAIR_CNT];

    // known register addresses, used by the error answer and its check
    function automatic logic reg_known(input logic [ADDR_W-1:0] addr);
        return (addr == ADDR_CTRL) || (addr == ADDR_SEL) || (addr == ADDR_STAT);
    endfunction

    // counter step with wrap at four periods; out-of-range phase after a range change restarts
    function automatic logic [7:0] next_phase(input logic [7:0] ph, input logic [1:0] step,
                                              input logic [7:0] n);
        logic [9:0] lim;
        logic [9:0] s;
        lim = {n, 2'h0};
        s   = {2'h0, ph} + {8'h00, step};
        if ({2'h0, ph} >= lim) begin
            s = 10'h000;
        end else if (s >= lim) begin
            s = s - lim;
        end
        return s[7:0];
    endfunction

    // apb phases; pready rises for the access cycle, so every transfer has no wait state
    assign apb_setup  = I_PSEL && !I_PENABLE;
    assign apb_access = I_PSEL && I_PENABLE && O_PREADY;

    // read mux; status shows the loop's own state and the active tap count
    always_comb begin
        rdata = '0;
        unique case (I_PADDR)
            ADDR_CTRL: rdata[CTRL_RANGE_LSB +: 2] = range_select;
            ADDR_SEL:  rdata[15:0] = pair_sel;
            ADDR_STAT: begin
                rdata[STAT_LOCK_BIT]      = (loop_state == ST_LOCK);
                rdata[STAT_ALIGN_BIT]     = aligned;
                rdata[STAT_TAPS_LSB +: 8] = taps;
            end
            default:   rdata = '0;
        endcase
    end

    // bus answer registers; unmapped addresses answer with an error and zero data
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            O_PREADY  <= 1'b0;
            O_PRDATA  <= '0;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY  <= apb_setup;
            O_PSLVERR <= apb_setup && !reg_known(I_PADDR);
            if (apb_setup && !I_PWRITE) begin
                O_PRDATA <= rdata;
            end
        end
    end

    // configuration writes take effect only at the completing access edge
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            range_select <= CTRL_RST;
            pair_sel     <= SEL_RST;
        end else if (apb_access && I_PWRITE) begin
            if (I_PADDR == ADDR_CTRL) begin
                range_select <= I_PWDATA[CTRL_RANGE_LSB +: 2];
            end
            if (I_PADDR == ADDR_SEL) begin
                pair_sel <= I_PWDATA[15:0];
            end
        end
    end

    // taps per nominal period follow the range select
    assign taps = taps_for_range(range_select);

    // edge detection on the synchronous clock pins
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            ref_prev      <= 1'b0;
            feedback_prev <= 1'b0;
        end else begin
            ref_prev      <= I_REF_CLOCK;
            feedback_prev <= I_FEEDBACK_INPUT;
        end
    end

    assign ref_rise      = I_REF_CLOCK && !ref_prev;
    assign feedback_rise = I_FEEDBACK_INPUT && !feedback_prev;
    // a reference edge without a feedback edge pulls every output one tap earlier
    assign slip          = ref_rise && !feedback_rise;

    // phase counter; whatever output drives feedback, the loop walks the counter until
    // that pin's rising edge meets the reference, so its own skew, inversion or division
    // is cancelled and carried over to all other pairs; one tap per reference edge is
    // slow to acquire but never overshoots
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            phase <= 8'h00;
        end else begin
            phase <= next_phase(phase, slip ? 2'h2 : 2'h1, taps);
        end
    end

    // lock detection counts aligned reference edges in a row
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            loop_state <= ST_HUNT;
            hit_cnt    <= 3'h0;
            aligned    <= 1'b0;
        end else if (ref_rise) begin
            aligned <= feedback_rise;
            unique case (loop_state)
                ST_HUNT: begin
                    if (!feedback_rise) begin
                        hit_cnt <= 3'h0;
                    end else if (hit_cnt == LOCK_REFS - 3'h1) begin
                        loop_state <= ST_LOCK;
                    end else begin
                        hit_cnt <= hit_cnt + 3'h1;
                    end
                end
                ST_LOCK: begin
                    if (!feedback_rise) begin
                        loop_state <= ST_HUNT;
                        hit_cnt    <= 3'h0;
                    end
                end
            endcase
        end
    end

    // one decoder and one generator per pair, all running side by side
    for (genvar p = 0; p < PAIR_CNT; p++) begin : g_pair
        psk_sel_decode #(
            .PAIR   (p)
        ) u_dec (
            .i_low  (pair_sel[p*SEL_PAIR_STRIDE + SEL_LOW_LSB +: 2]),
            .i_high (pair_sel[p*SEL_PAIR_STRIDE + SEL_HIGH_LSB +: 2]),
            .o_kind (kind[p]),
            .o_skew (skew[p])
        );
        psk_pair_gen u_gen (
            .i_clk   (I_CORE_CLK),
            .i_rst   (I_RST),
            .i_phase (phase),
            .i_taps  (taps),
            .i_kind  (kind[p]),
            .i_skew  (skew[p]),
            .o_q     (pair_q[p])
        );
    end

    assign O_OUTPUT_PAIR_ONE   = pair_q[0];
    assign O_OUTPUT_PAIR_TWO   = pair_q[1];
    assign O_OUTPUT_PAIR_THREE = pair_q[PAIR_THREE];
    assign O_OUTPUT_PAIR_FOUR  = pair_q[PAIR_FOUR];

    // checks on bus answers, pair waveforms and the loop
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RST);

    logic [7:0] all_q;
    logic       cfg_skew1;
    logic       cfg_inv;
    logic       cfg_div;
    assign all_q     = {O_OUTPUT_PAIR_FOUR, O_OUTPUT_PAIR_THREE,
                        O_OUTPUT_PAIR_TWO, O_OUTPUT_PAIR_ONE};
    assign cfg_skew1 = (pair_sel[7:0] == 8'h56);
    assign cfg_inv   = (pair_sel[15:12] == 4'ha) && (pair_sel[3:0] == 4'h5);
    assign cfg_div   = (pair_sel[15:8] == 8'h0a);

    a_apb_ready_next: assert property (apb_setup |=> O_PREADY ##1 !O_PREADY || apb_setup)
        else $error("apb ready not raised after setup");
    a_apb_unmapped_err: assert property (apb_setup && !reg_known(I_PADDR) |=> O_PSLVERR)
        else $error("unmapped address answered without error");
    a_zero_skew_all: assert property (pair_sel == SEL_RST |=>
        (all_q == 8'h00) || (all_q == 8'hff))
        else $error("outputs not aligned with all selects open");
    a_slip_on_miss: assert property (ref_rise && !feedback_rise && taps == $past(taps)
        |=> phase == next_phase($past(phase), 2'h2, $past(taps)))
        else $error("phase did not slip on a missed feedback edge");
    a_lock_after_hits: assert property (loop_state == ST_HUNT && ref_rise && feedback_rise
        && hit_cnt == LOCK_REFS - 3'h1 |=> loop_state == ST_LOCK)
        else $error("loop failed to declare lock");
    a_lock_lost_miss: assert property (loop_state == ST_LOCK && slip |=>
        loop_state == ST_HUNT && !aligned)
        else $error("lock kept after a missed edge");
    // the range must also have held one cycle earlier, or a restarted phase breaks the step
    a_skew_one_unit: assert property (cfg_skew1 && $stable(pair_sel) && $stable(range_select)
        && $past($stable(range_select)) && !$past(slip)
        |=> O_OUTPUT_PAIR_ONE[0] == $past(O_OUTPUT_PAIR_TWO[0]))
        else $error("pair one not one unit behind pair two");
    a_invert_pair_four: assert property (cfg_inv |=> O_OUTPUT_PAIR_FOUR == ~O_OUTPUT_PAIR_ONE)
        else $error("pair four not inverted against pair one");
    // both compared output values must come from the divided setup and a settled phase
    a_div_fall_common: assert property (cfg_div && $past(cfg_div) && $past(cfg_div, 2)
        && $stable(range_select) && $past($stable(range_select))
        && $past($stable(range_select), 2)
        && $fell(O_OUTPUT_PAIR_THREE[0]) |-> $fell(O_OUTPUT_PAIR_FOUR[0]))
        else $error("half and quarter outputs do not fall together");
    a_taps_in_range: assert property ($stable(range_select) && $past($stable(range_select))
        |-> {2'h0, phase} < {taps, 2'h0})
        else $error("phase counter outside four periods");

    c_lock_reached: cover property (loop_state == ST_HUNT ##1 loop_state == ST_LOCK);
    c_div_falls: cover property (cfg_div && $fell(O_OUTPUT_PAIR_THREE[0]));
    c_inverted: cover property (cfg_inv && $rose(O_OUTPUT_PAIR_FOUR[0]));
    c_bus_error: cover property (O_PREADY && O_PSLVERR);

endmodule

// file: src/psk_pkg.sv
// psk_pkg: constants, types and decode helpers of the programmable skew clock buffer.
// assumes one core clock that acts as the tap clock of the phase counter.
package psk_pkg;

    // apb geometry and register byte addresses
    localparam int          ADDR_W    = 12;
    localparam int          DATA_W    = 32;
    localparam int          PAIR_CNT  = 4;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_SEL  = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;

    // field positions
    localparam int CTRL_RANGE_LSB  = 0;
    localparam int SEL_PAIR_STRIDE = 4;
    localparam int SEL_LOW_LSB     = 0;
    localparam int SEL_HIGH_LSB    = 2;
    localparam int STAT_LOCK_BIT   = 0;
    localparam int STAT_ALIGN_BIT  = 1;
    localparam int STAT_TAPS_LSB   = 8;

    // reset values: range tied low, every select left open
    localparam logic [1:0]  CTRL_RST = 2'h0;
    localparam logic [15:0] SEL_RST  = 16'h5555;

    // three-level input codes
    localparam logic [1:0] LVL_LOW  = 2'h0;
    localparam logic [1:0] LVL_MID  = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;

    // taps per nominal period for low, mid and high range
    localparam logic [7:0] TAPS_LOW  = 8'h2c;
    localparam logic [7:0] TAPS_MID  = 8'h1a;
    localparam logic [7:0] TAPS_HIGH = 8'h10;

    // aligned reference edges in a row before lock is declared
    localparam logic [2:0] LOCK_REFS = 3'h4;

    // pair indices with special high-high functions
    localparam int PAIR_THREE = 2;
    localparam int PAIR_FOUR  = 3;

    typedef enum logic [1:0] {
        KIND_SKEW = 2'h0,
        KIND_DIV2 = 2'h1,
        KIND_INV  = 2'h2,
        KIND_DIV4 = 2'h3
    } psk_kind_t;

    typedef enum logic {
        ST_HUNT = 1'b0,
        ST_LOCK = 1'b1
    } psk_loop_state_t;

    // open or illegal code counts as mid, as an unconnected pin would
    function automatic logic signed [4:0] lvl_value(input logic [1:0] code);
        if (code == LVL_LOW) begin
            return -5'sd1;
        end else if (code == LVL_HIGH) begin
            return 5'sd1;
        end
        return 5'sd0;
    endfunction

    // taps per period from the range select code
    function automatic logic [7:0] taps_for_range(input logic [1:0] code);
        if (code == LVL_LOW) begin
            return TAPS_LOW;
        end else if (code == LVL_HIGH) begin
            return TAPS_HIGH;
        end
        return TAPS_MID;
    endfunction

endpackage

// file: src/psk_sel_decode.sv
// psk_sel_decode: turns one pair's two three-level selects into a function and a skew.
// assumes select codes come from a register, so no settling is needed.
`timescale 1ns/1ns
module psk_sel_decode #(
    parameter int PAIR = 0
) (
    // select codes
    input  wire logic [1:0]         i_low,
    input  wire logic [1:0]         i_high,
    // decoded function
    output psk_pkg::psk_kind_t      o_kind,
    output logic signed [4:0]       o_skew
);
    import psk_pkg::*;

    logic signed [4:0] w;

    // nine-way decode; outer pairs span four units, inner pairs six in steps of two
    always_comb begin
        w      = (lvl_value(i_high) <<< 1) + lvl_value(i_high) + lvl_value(i_low);
        o_kind = KIND_SKEW;
        o_skew = 5'sd0;
        if (PAIR < PAIR_THREE) begin
            o_skew = w;
        end else if (w == -5'sd4) begin
            o_kind = KIND_DIV2;
        end else if (w == 5'sd4) begin
            o_kind = (PAIR == PAIR_THREE) ? KIND_DIV4 : KIND_INV;
        end else begin
            o_skew = w <<< 1;
        end
    end

endmodule

// file: src/psk_pair_gen.sv
// psk_pair_gen: builds one output pair from the shared phase counter.
// assumes the phase counter wraps at four nominal periods.
`timescale 1ns/1ns
module psk_pair_gen (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    // shared timing
    input  wire logic [7:0]         i_phase,
    input  wire logic [7:0]         i_taps,
    // pair function
    input  psk_pkg::psk_kind_t      i_kind,
    input  wire logic signed [4:0]  i_skew,
    // pair outputs
    output logic [1:0]              o_q
);
    import psk_pkg::*;

    logic [9:0] n10;
    logic [9:0] x;
    logic [9:0] r1;
    logic [9:0] r2;
    logic [9:0] r4;
    logic       next_bit;

    // every function is a tap of one counter, so dividers add no delay of their own
    always_comb begin
        n10 = {2'h0, i_taps};
        x   = {2'h0, i_phase} + (n10 << 2) - 10'(i_skew);
        r1  = x % n10;
        r2  = x % (n10 << 1);
        r4  = x % (n10 << 2);
        next_bit = 1'b0;
        unique case (i_kind)
            KIND_SKEW: next_bit = (r1 < (n10 >> 1));
            KIND_INV:  next_bit = !(r1 < (n10 >> 1));
            KIND_DIV2: next_bit = (r2 < n10);
            KIND_DIV4: next_bit = (r4 >= n10) && (r4 < (n10 * 3));
        endcase
    end

    // both pins of a pair come from one flop value, keeping them in step
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_q <= 2'h0;
        end else begin
            o_q <= {2{next_bit}};
        end
    end

endmodule

// file: testbench/psk_board_model.sv
// psk_board_model: reference clock source and the board wire that closes the feedback loop.
// assumes the core clock paces the source and the pair outputs arrive as registered pins.
`timescale 1ns/1ns
module psk_board_model (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // board settings
    input  wire logic [9:0] i_ref_period,
    input  wire logic [1:0] i_fb_pair,
    input  wire logic [7:0] i_q,
    // pins toward the buffer
    output logic            o_ref,
    output logic            o_fb
);
    logic [9:0] cnt;

    // free-running source; a period change keeps the count, which wraps at the new period
    always @(posedge i_clk) begin
        if (i_rst || cnt >= i_ref_period - 10'h1) begin
            cnt <= 10'h0;
        end else begin
            cnt <= cnt + 10'h1;
        end
    end

    // high for the first half, quiet while reset so no edge is seen early
    assign o_ref = !i_rst && (cnt < (i_ref_period >> 1));
    // bit zero of one pair goes back; a plain wire adds no cycles to the loop
    // a single buffer, no cascade: no jitter build-up, no wire delay to skew back
    assign o_fb = i_q[{i_fb_pair, 1'b0}];
endmodule

// file: testbench/programmable_skew_clock_buffer_bench.sv
// programmable_skew_clock_buffer_bench: self-checking bench of the skew clock buffer.
// assumes the board model closes the loop and apb answers through O_PREADY.
`timescale 1ns/1ns
module programmable_skew_clock_buffer_bench;
    import psk_pkg::*;
    logic        clk        = 1'h0;
    logic        rst        = 1'h1;
    logic        psel       = 1'h0;
    logic        penable    = 1'h0;
    logic        pwrite     = 1'h0;
    logic [11:0] paddr      = 12'h000;
    logic [31:0] pwdata     = 32'h0;
    logic [9:0]  ref_period = 10'h02c;
    logic [1:0]  fb_pair    = 2'h0;
    logic [31:0] rng        = 32'h0000f59c;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ref_clk;
    logic        fb;
    wire  [7:0]  q;
    logic [7:0]  last_q;
    logic        last_ref;
    logic [31:0] rdv;
    logic        errv;
    int          err_count  = 0;
    int          cmp_count  = 0;

    always #4 clk = ~clk;

    psk_clock_buffer dut (
        .I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_REF_CLOCK(ref_clk),
        .I_FEEDBACK_INPUT(fb), .O_OUTPUT_PAIR_ONE(q[1:0]), .O_OUTPUT_PAIR_TWO(q[3:2]),
        .O_OUTPUT_PAIR_THREE(q[5:4]), .O_OUTPUT_PAIR_FOUR(q[7:6]));

    psk_board_model board (
        .i_clk(clk), .i_rst(rst), .i_ref_period(ref_period), .i_fb_pair(fb_pair),
        .i_q(q), .o_ref(ref_clk), .o_fb(fb));

    // pins are sampled mid-cycle, well away from the edge that moves them
    always @(negedge clk) begin
        last_ref <= ref_clk;
        last_q   <= q;
    end

    task automatic final_report();
        $display("mismatches %0d, comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // a wait that runs dry counts as a mismatch and ends the run
    task automatic timed_out();
        check(32'h0, 32'h1);
        final_report();
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'h1) break;
        end
        if (n == 16) timed_out();
        rdv = prdata;
        errv = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    function automatic int lvl(input logic [1:0] c);
        return (c == 2'h0) ? -1 : ((c == 2'h2) ? 1 : 0);
    endfunction

    // pairs three and four step in two units
    function automatic int skew_of(input int p, input logic [3:0] nib);
        int v;
        v = 3 * lvl(nib[3:2]) + lvl(nib[1:0]);
        return (p >= 2) ? 2 * v : v;
    endfunction

    function automatic int wrap(input int v, input int t);
        return ((v % t) + t) % t;
    endfunction

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // cycles from a reference rise to the next rise of pair p
    task automatic rise_after_ref(input int p, output int d);
        int n;
        for (n = 0; n < 600; n++) begin
            @(negedge clk);
            if (ref_clk && !last_ref) break;
        end
        for (d = 0; d < 600; d++) begin
            if (q[2*p] && !last_q[2*p]) break;
            @(negedge clk);
        end
        if (n == 600 || d == 600) timed_out();
    endtask

    task automatic period_of(input int p, output int d);
        rise_after_ref(p, d);
        for (d = 1; d < 600; d++) begin
            @(negedge clk);
            if (q[2*p] && !last_q[2*p]) break;
        end
        if (d == 600) timed_out();
    endtask

    // lock status is only trusted after a few reference periods have gone by
    task automatic setup(input logic [1:0] rc, input logic [15:0] sel, input int fbp, input int per);
        int n;
        apb(1'h1, ADDR_CTRL, {30'h0, rc});
        apb(1'h1, ADDR_SEL, {16'h0, sel});
        fb_pair    <= fbp[1:0];
        ref_period <= per[9:0];
        repeat (3 * per) @(posedge clk);
        for (n = 0; n < 3000; n++) begin
            apb(1'h0, ADDR_STAT, 32'h0);
            if (rdv[STAT_LOCK_BIT] === 1'h1) break;
        end
        if (n == 3000) timed_out();
    endtask

    // every pair in a skew function against the pair wired to feedback
    task automatic verify(input logic [15:0] sel, input int fbp, input int t);
        int d;
        for (int p = 0; p < 4; p++) begin
            rise_after_ref(p, d);
            check(d, wrap(skew_of(p, sel[4*p +: 4]) - skew_of(fbp, sel[4*fbp +: 4]), t));
        end
    endtask

    initial begin
        int d;
        logic [15:0] sel;
        logic [3:0] nib;
        repeat (7) @(posedge clk);
        @(negedge clk);
        check(q, 8'h00);
        @(posedge clk);
        rst <= 1'h0;
        // defaults, a read-only write and an unmapped address
        apb(1'h0, ADDR_CTRL, 32'h0);
        check(rdv, {30'h0, CTRL_RST});
        apb(1'h0, ADDR_SEL, 32'h0);
        check(rdv, 32'h5555);
        apb(1'h1, ADDR_STAT, 32'hffffffff);
        apb(1'h0, ADDR_STAT, 32'h0);
        check(rdv[15:8], 8'h2c);
        apb(1'h0, 12'h00c, 32'h0);
        check(rdv, 32'h0);
        check({31'h0, errv}, 32'h1);
        // all selects open: eight aligned outputs
        setup(2'h0, 16'h5555, 0, 44);
        verify(16'h5555, 0, 44);
        @(negedge clk);
        check(q, q[0] ? 8'hff : 8'h00);
        // random skews against a zero skew feedback pair
        for (int r = 0; r < 4; r++) begin
            sel = 16'h5555;
            for (int p = 0; p < 3; p++) begin
                nib = {2'(xs() % 32'h3), 2'(xs() % 32'h3)};
                if (p == 2 && (nib == 4'h0 || nib == 4'ha)) nib = 4'h5;
                sel[4*p +: 4] = nib;
            end
            setup(2'h0, sel, 3, 44);
            verify(sel, 3, 44);
        end
        // skewed feedback widens the range to ten units
        setup(2'h0, 16'h5950, 0, 44);
        verify(16'h5950, 0, 44);
        // pair one a single unit behind zero skew feedback on pair two
        setup(2'h0, 16'h5556, 1, 44);
        verify(16'h5556, 1, 44);
        // pair four inverted, then used as feedback
        setup(2'h0, 16'ha555, 0, 44);
        repeat (88) begin
            @(negedge clk);
            check(q[7:6], {30'h0, ~q[1:0]});
        end
        setup(2'h0, 16'ha555, 3, 44);
        rise_after_ref(0, d);
        check(d, 22);
        // quarter-rate feedback multiplies; half and quarter outputs together
        setup(2'h2, 16'h0a55, 2, 64);
        apb(1'h0, ADDR_STAT, 32'h0);
        check(rdv[15:8], 8'h10);
        rise_after_ref(2, d);
        check(d, 0);
        period_of(0, d);
        check(d, 16);
        period_of(3, d);
        check(d, 32);
        repeat (64) begin
            @(negedge clk);
            if (!q[4] && last_q[4]) check({q[6], last_q[6]}, 2'h1);
        end
        // mid range sets the unit count per period
        setup(2'h1, 16'h5555, 1, 26);
        period_of(1, d);
        check(d, 26);
        final_report();
    end
endmodule
